// ==== rtl/dsp_out_defs.svh ====
// Constants of the accumulator store, round, saturate and shift path.
// Assumes inclusion by bare name from the rtl files.
// Function
// - Bit 39 overflow sets sticky flag, accumulator wraps
// - Trap enable lets catastrophic overflow raise trap
// - Write-back except plain, negated multiply, distance ops
// - Write-back over X bus, any data address
// - Direct mode puts rounded value into pointer
// - Indirect mode stores at pointer, pointer plus 2
// - Round mode bit picks conventional or convergent
// - No rounding stores truncated high word
// - Conventional adds bit 15 to high word
// - Convergent at exact half uses bit 16
// - Stores write target accumulator through saturation
// - Write-back values are always rounded
// - Write saturation leaves source accumulator unchanged
// - Saturate writes to 0x7FFF or 0x8000
// - Saturation sign from bit 39, overflow status
// - Saturation off passes rounded value unchanged
// - Shifter shifts up to 16, accumulators or X
// - Signed amount: positive right, negative left, zero
// - 40-bit shifter, 40 or 16 bit result
// - X data at 16..31 right, 0..15 left
// - Saturated flags set by adder, cleared by software
`ifndef DSP_OUT_DEFS_SVH
`define DSP_OUT_DEFS_SVH
`define ADDR_CONFIG 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_WBPTR 8'h08
`define ADDR_ACCA_LO 8'h0C
`define ADDR_ACCA_HI 8'h10
`define ADDR_ACCB_LO 8'h14
`define ADDR_ACCB_HI 8'h18
`define ADDR_UNMAPPED 8'hFF
`define CFG_ROUND_BIT 0
`define CFG_WRSAT_BIT 1
`define CFG_TRAP_BIT 2
`define STAT_FLAG_A_BIT 0
`define STAT_FLAG_B_BIT 1
`define WBPTR_RESET 16'h0000
`define WB_STEP 16'h0002
`define SAT_POS 16'h7FFF
`define SAT_NEG 16'h8000
`define SHIFT_LIMIT 5'h10
`endif

// ==== rtl/dsp_out_pkg.sv ====
// Types of the accumulator store, round, saturate and shift path.
// Assumes no other package.
`default_nettype none
package dsp_out_pkg;
  typedef enum logic [1:0] {OP_NONE, OP_STORE, OP_STORE_ROUND, OP_MAC}
    op_code_e;
  typedef enum logic [2:0] {MK_MULT_ACC, MK_MULT_SUB, MK_CLEAR, MK_MOVE,
    MK_PLAIN_MULT, MK_NEG_MULT, MK_DIST_SQ, MK_DIST_SQ_ACC} mac_kind_e;
  typedef enum logic [1:0] {WB_NONE, WB_DIRECT, WB_INDIRECT} wb_mode_e;
  typedef enum logic [1:0] {SRC_ACC_A, SRC_ACC_B, SRC_XBUS} shift_src_e;
  typedef enum logic [2:0] {BUS_IDLE = 3'b001, BUS_WRITE = 3'b010,
    BUS_READ = 3'b100} bus_phase_e;
  typedef struct packed {
    logic [39:0] accA;
    logic [39:0] accB;
    logic flagA;
    logic flagB;
    logic roundMode;
    logic data_write_saturate_enable;
    logic trapEn;
    logic [15:0] wbPtr;
    bus_phase_e phase;
    logic [7:0] busAddr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic xWrEn;
    logic [15:0] xWrAddr;
    logic [15:0] xWrData;
    logic trap;
    logic [39:0] shiftResult;
    logic shiftDone;
  } out_state_s;
endpackage
`default_nettype wire

// ==== rtl/round_saturate.sv ====
// Combinational round and data-write saturation of an accumulator.
// Assumes a 40-bit signed accumulator at the input.
`timescale 1ns/100ps
`default_nettype none
`include "dsp_out_defs.svh"
module round_saturate (
  input wire logic [39:0] acc,
  input wire logic roundEn,
  input wire logic convergent,
  input wire logic satEn,
  output logic [15:0] dataOut
);
  logic inc;
  logic [24:0] rounded;
  logic posOvf;
  logic negOvf;
  always_comb
  begin
    inc = 1'b0;
    if (roundEn)
    begin
      if (convergent && acc[15:0] == 16'h8000)
        inc = acc[16];
      else
        inc = acc[15];
    end
    rounded = {acc[39], acc[39:16]} + {24'h000000, inc};
    posOvf = !acc[39] && (rounded[24:15] != 10'h000);
    negOvf = acc[39] && rounded[24] && (rounded[23:15] != 9'h1FF);
    dataOut = rounded[15:0];
    if (satEn && posOvf)
      dataOut = `SAT_POS;
    else if (satEn && negOvf)
      dataOut = `SAT_NEG;
  end
endmodule // round_saturate
`default_nettype wire

// ==== rtl/barrel_shift.sv ====
// 40-bit bidirectional barrel shifter, one cycle, signed amount.
// Assumes operand already placed by the caller.
`timescale 1ns/100ps
`default_nettype none
`include "dsp_out_defs.svh"
module barrel_shift #(
  parameter logic [4:0] SHIFT_MAX = `SHIFT_LIMIT
) (
  input wire logic [39:0] operand,
  input wire logic signed [5:0] amount,
  input wire logic arith,
  output logic [39:0] result
);
  logic [5:0] absAmt;
  logic [4:0] mag;
  always_comb
  begin
    absAmt = amount[5] ? 6'(-amount) : amount;
    mag = (absAmt > {1'b0, SHIFT_MAX}) ? SHIFT_MAX : absAmt[4:0];
    if (amount[5])
      result = operand << mag;
    else if (arith)
      result = $signed(operand) >>> mag;
    else
      result = operand >> mag;
  end
endmodule // barrel_shift
`default_nettype wire

// ==== rtl/dsp_output_path.sv ====
// Accumulators, overflow flags, store and write-back path, shifter,
// and an AHB-Lite register slave.
// Assumes the decoder and adder sequencing on clk_sys, zero wait bus.
//
// Our own choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "dsp_out_defs.svh"
module dsp_output_path
  import dsp_out_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic addValid,
  input wire logic addAcc,
  input wire logic [39:0] addOperand,
  input wire logic opValid,
  input wire op_code_e opCode,
  input wire logic opAcc,
  input wire logic [15:0] opAddr,
  input wire mac_kind_e macKind,
  input wire wb_mode_e wbMode,
  input wire logic shiftValid,
  input wire shift_src_e shiftSrc,
  input wire logic signed [5:0] shiftAmt,
  input wire logic shiftArith,
  input wire logic shiftMcu,
  input wire logic [15:0] xBusIn,
  output logic xWrEn,
  output logic [15:0] xWrAddr,
  output logic [15:0] xWrData,
  output logic [15:0] wbPointer,
  output logic accASaturated,
  output logic accBSaturated,
  output logic arithTrap,
  output logic [39:0] shiftResult,
  output logic shiftDone
);
  out_state_s s;
  out_state_s next_s;
  logic [39:0] addBase;
  logic [39:0] addSum;
  logic addOvf;
  logic storeGo;
  logic wbGo;
  logic [39:0] srcAcc;
  logic roundEn;
  logic [15:0] roundOut;
  logic shiftRight;
  logic [39:0] shiftOperand;
  logic [39:0] shiftOut;
  logic [15:0] mcuWord;
  logic busTake;
  logic stsClrA;

  function automatic logic wbAllowed(input mac_kind_e kind);
    wbAllowed = !(kind == MK_PLAIN_MULT || kind == MK_NEG_MULT ||
      kind == MK_DIST_SQ || kind == MK_DIST_SQ_ACC);
  endfunction

  function automatic logic [7:0] busIndex(input logic [31:0] addr);
    busIndex = (addr[31:8] == 24'h000000) ? addr[7:0] : `ADDR_UNMAPPED;
  endfunction

  function automatic logic [31:0] readReg(input logic [7:0] addr,
    input out_state_s st);
    readReg = 32'h00000000;
    if (addr == `ADDR_CONFIG)
      readReg = {29'h0, st.trapEn, st.data_write_saturate_enable, st.roundMode};
    else if (addr == `ADDR_STATUS)
      readReg = {30'h0, st.flagB, st.flagA};
    else if (addr == `ADDR_WBPTR)
      readReg = {16'h0000, st.wbPtr};
    else if (addr == `ADDR_ACCA_LO)
      readReg = st.accA[31:0];
    else if (addr == `ADDR_ACCA_HI)
      readReg = {24'h000000, st.accA[39:32]};
    else if (addr == `ADDR_ACCB_LO)
      readReg = st.accB[31:0];
    else if (addr == `ADDR_ACCB_HI)
      readReg = {24'h000000, st.accB[39:32]};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Adder pass, store source selection, shifter operand

  assign addBase = addAcc ? s.accB : s.accA;
  assign addSum = addBase + addOperand;
  assign addOvf = addValid && (addBase[39] == addOperand[39]) &&
    (addSum[39] != addBase[39]);
  assign storeGo = opValid &&
    (opCode == OP_STORE || opCode == OP_STORE_ROUND);
  assign wbGo = opValid && opCode == OP_MAC && wbAllowed(macKind) &&
    wbMode != WB_NONE;
  // Write-back reads the non-target accumulator
  assign srcAcc = ((opCode == OP_MAC) ^ opAcc) ? s.accB : s.accA;
  assign roundEn = (opCode != OP_STORE);
  assign shiftRight = !shiftAmt[5];
  assign mcuWord = shiftRight ? shiftOut[31:16] : shiftOut[15:0];
  assign busTake = hsel && htrans[1] && hready;
  assign stsClrA = (s.phase == BUS_WRITE) && (s.busAddr == `ADDR_STATUS) &&
    hwdata[`STAT_FLAG_A_BIT];

  always_comb
  begin
    shiftOperand = s.accA;
    case (shiftSrc)
      SRC_ACC_A: shiftOperand = s.accA;
      SRC_ACC_B: shiftOperand = s.accB;
      SRC_XBUS:
      begin
        if (shiftRight)
          shiftOperand = {{8{xBusIn[15] & shiftArith}}, xBusIn,
            16'h0000};
        else
          shiftOperand = {24'h000000, xBusIn};
      end
      default: shiftOperand = s.accA;
    endcase
  end

  round_saturate u_round (
    .acc(srcAcc),
    .roundEn(roundEn),
    .convergent(s.roundMode),
    .satEn(s.data_write_saturate_enable),
    .dataOut(roundOut)
  );

  barrel_shift #(
    .SHIFT_MAX(`SHIFT_LIMIT)
  ) u_shift (
    .operand(shiftOperand),
    .amount(shiftAmt),
    .arith(shiftArith),
    .result(shiftOut)
  );

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    next_s = s;
    next_s.hrdata = 32'h00000000;
    next_s.hreadyout = 1'b1;
    next_s.hresp = 1'b0;
    next_s.xWrEn = 1'b0;
    next_s.trap = 1'b0;
    next_s.shiftDone = 1'b0;
    next_s.phase = BUS_IDLE;
    // Bus write data phase, hardware below overrides
    if (s.phase == BUS_WRITE)
    begin
      if (s.busAddr == `ADDR_CONFIG)
      begin
        next_s.roundMode = hwdata[`CFG_ROUND_BIT];
        next_s.data_write_saturate_enable = hwdata[`CFG_WRSAT_BIT];
        next_s.trapEn = hwdata[`CFG_TRAP_BIT];
      end
      else if (s.busAddr == `ADDR_STATUS)
      begin
        if (hwdata[`STAT_FLAG_A_BIT])
          next_s.flagA = 1'b0;
        if (hwdata[`STAT_FLAG_B_BIT])
          next_s.flagB = 1'b0;
      end
      else if (s.busAddr == `ADDR_WBPTR)
        next_s.wbPtr = hwdata[15:0];
      else if (s.busAddr == `ADDR_ACCA_LO)
        next_s.accA[31:0] = hwdata;
      else if (s.busAddr == `ADDR_ACCA_HI)
        next_s.accA[39:32] = hwdata[7:0];
      else if (s.busAddr == `ADDR_ACCB_LO)
        next_s.accB[31:0] = hwdata;
      else if (s.busAddr == `ADDR_ACCB_HI)
        next_s.accB[39:32] = hwdata[7:0];
    end
    // Adder pass wraps, no saturation
    if (addValid)
    begin
      if (addAcc)
        next_s.accB = addSum;
      else
        next_s.accA = addSum;
    end
    if (addOvf)
    begin
      if (addAcc)
        next_s.flagB = 1'b1;
      else
        next_s.flagA = 1'b1;
      next_s.trap = s.trapEn;
    end
    // Stores never touch the accumulators
    if (storeGo)
    begin
      next_s.xWrEn = 1'b1;
      next_s.xWrAddr = opAddr;
      next_s.xWrData = roundOut;
    end
    else if (wbGo)
    begin
      if (wbMode == WB_DIRECT)
        next_s.wbPtr = roundOut;
      else
      begin
        next_s.xWrEn = 1'b1;
        next_s.xWrAddr = s.wbPtr;
        next_s.xWrData = roundOut;
        next_s.wbPtr = s.wbPtr + `WB_STEP;
      end
    end
    if (shiftValid)
    begin
      next_s.shiftResult = shiftMcu ? {24'h000000, mcuWord} : shiftOut;
      next_s.shiftDone = 1'b1;
    end
    // Address phase, read data from the updated state
    if (busTake)
    begin
      next_s.busAddr = busIndex(haddr);
      next_s.phase = hwrite ? BUS_WRITE : BUS_READ;
      if (!hwrite)
        next_s.hrdata = readReg(busIndex(haddr), next_s);
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s <= '0;
      s.phase <= BUS_IDLE;
      s.hreadyout <= 1'b1;
      s.wbPtr <= `WBPTR_RESET;
    end
    else
      s <= next_s;
  end

  assign hreadyout = s.hreadyout;
  assign hresp = s.hresp;
  assign hrdata = s.hrdata;
  assign xWrEn = s.xWrEn;
  assign xWrAddr = s.xWrAddr;
  assign xWrData = s.xWrData;
  assign wbPointer = s.wbPtr;
  assign accASaturated = s.flagA;
  assign accBSaturated = s.flagB;
  assign arithTrap = s.trap;
  assign shiftResult = s.shiftResult;
  assign shiftDone = s.shiftDone;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  property p_ovf_flag;
    addValid && !addAcc && addOvf |=> s.flagA;
  endproperty
  a_ovf_flag: assert property (p_ovf_flag)
    else $error("flag A not set");

  property p_wrap;
    addValid && !addAcc |=> s.accA == $past(addSum);
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("accumulator not wrapped");

  property p_trap;
    s.trap == $past(addOvf && s.trapEn);
  endproperty
  a_trap: assert property (p_trap)
    else $error("trap mismatch");

  property p_sticky;
    s.flagA && !stsClrA |=> s.flagA;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("flag A lost");

  property p_excluded;
    opValid && opCode == OP_MAC && !wbAllowed(macKind) &&
      s.phase != BUS_WRITE |=> !s.xWrEn ##0 $stable(s.wbPtr);
  endproperty
  a_excluded: assert property (p_excluded)
    else $error("excluded write-back");

  property p_direct;
    wbGo && wbMode == WB_DIRECT |=> s.wbPtr == $past(roundOut) && !s.xWrEn;
  endproperty
  a_direct: assert property (p_direct)
    else $error("direct write-back");

  property p_indirect;
    wbGo && wbMode == WB_INDIRECT |=> s.xWrEn &&
      s.xWrAddr == $past(s.wbPtr) && s.wbPtr == $past(s.wbPtr) + `WB_STEP;
  endproperty
  a_indirect: assert property (p_indirect)
    else $error("indirect write-back");

  property p_trunc;
    storeGo && opCode == OP_STORE && !s.data_write_saturate_enable
      |=> s.xWrData == $past(srcAcc[31:16]);
  endproperty
  a_trunc: assert property (p_trunc)
    else $error("truncated store");

  property p_sat_pos;
    storeGo && s.data_write_saturate_enable && !srcAcc[39] && srcAcc[39:16] > 24'h007FFF
      |=> s.xWrData == `SAT_POS;
  endproperty
  a_sat_pos: assert property (p_sat_pos)
    else $error("no saturation");

  property p_keep_acc;
    storeGo && !addValid && s.phase != BUS_WRITE
      |=> $stable(s.accA) && $stable(s.accB);
  endproperty
  a_keep_acc: assert property (p_keep_acc)
    else $error("store changed acc");

  property p_shift_zero;
    shiftValid && shiftAmt == 6'sd0 && shiftSrc == SRC_ACC_A && !shiftMcu
      |=> s.shiftDone && s.shiftResult == $past(s.accA);
  endproperty
  a_shift_zero: assert property (p_shift_zero)
    else $error("zero shift");

  property p_round_conv;
    storeGo && opCode != OP_STORE && !s.roundMode && !s.data_write_saturate_enable
      |=> s.xWrData == $past(srcAcc[31:16] + {15'h0000, srcAcc[15]});
  endproperty
  a_round_conv: assert property (p_round_conv)
    else $error("conventional round");

  property p_sat_neg;
    storeGo && s.data_write_saturate_enable && srcAcc[39] && srcAcc[39:16] < 24'hFF8000
      |=> s.xWrData == `SAT_NEG;
  endproperty
  a_sat_neg: assert property (p_sat_neg)
    else $error("no negative saturation");

  property p_shift_mcu;
    shiftValid && shiftMcu |=> s.shiftResult[39:16] == 24'h000000;
  endproperty
  a_shift_mcu: assert property (p_shift_mcu)
    else $error("short shift result upper bits");
endmodule // dsp_output_path
`default_nettype wire

// ==== verification/x_write_sink.sv ====
// X data write bus sink: a word model of the combined X and Y space.
// Assumes byte addresses on xWrAddr and one word per xWrEn pulse.
`timescale 1ns/100ps
`default_nettype none
module x_write_sink (
  input wire logic clk_sys,
  input wire logic xWrEn,
  input wire logic [15:0] xWrAddr,
  input wire logic [15:0] xWrData,
  input wire logic [15:0] peekAddr,
  output logic [15:0] peekData,
  output logic [7:0] wrCount
);
  logic [15:0] mem [0:32767];
  assign peekData = mem[peekAddr[15:1]];
  initial wrCount = 8'h00;
  ////////////////////////////////////////////////////////////////////////
  // Any word of the 64 Kbyte space takes the write
  always @(posedge clk_sys)
    if (xWrEn === 1'b1)
    begin
      mem[xWrAddr[15:1]] <= xWrData;
      wrCount <= wrCount + 8'h01;
    end
endmodule // x_write_sink
`default_nettype wire

// ==== verification/accumulator_round_saturate_shift_tb_top.sv ====
// Bench of the accumulator store, round, saturate and shift path.
// Assumes the design files and x_write_sink compiled before it.
`timescale 1ns/100ps
`default_nettype none
`include "dsp_out_defs.svh"
module accumulator_round_saturate_shift_tb_top import dsp_out_pkg::*;;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp;
  logic [31:0] hrdata;
  logic addValid = 1'b0;
  logic addAcc = 1'b0;
  logic [39:0] addOperand = 40'h0;
  logic opValid = 1'b0;
  op_code_e opCode = OP_NONE;
  logic opAcc = 1'b0;
  logic [15:0] opAddr = 16'hFFFE;
  mac_kind_e macKind = MK_MULT_ACC;
  wb_mode_e wbMode = WB_NONE;
  logic shiftValid = 1'b0;
  shift_src_e shiftSrc = SRC_ACC_A;
  logic signed [5:0] shiftAmt = 6'sh0;
  logic shiftArith = 1'b0;
  logic shiftMcu = 1'b0;
  logic [15:0] xBusIn = 16'h8001;
  logic xWrEn, accASaturated, accBSaturated, arithTrap, shiftDone;
  logic [15:0] xWrAddr, xWrData, wbPointer;
  logic [39:0] shiftResult;
  logic [7:0] wrCount;
  logic [15:0] peekAddr = 16'h0000;
  logic [15:0] peekData;
  logic [31:0] rd;
  int mismatches = 0;
  int checks = 0;
  int nWr = 0;
  always #5 clk_sys = ~clk_sys;
  dsp_output_path DUT (.clk_sys(clk_sys), .arst_n(arst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .addValid(addValid), .addAcc(addAcc),
    .addOperand(addOperand), .opValid(opValid), .opCode(opCode),
    .opAcc(opAcc), .opAddr(opAddr), .macKind(macKind), .wbMode(wbMode),
    .shiftValid(shiftValid), .shiftSrc(shiftSrc), .shiftAmt(shiftAmt),
    .shiftArith(shiftArith), .shiftMcu(shiftMcu), .xBusIn(xBusIn),
    .xWrEn(xWrEn), .xWrAddr(xWrAddr), .xWrData(xWrData),
    .wbPointer(wbPointer), .accASaturated(accASaturated),
    .accBSaturated(accBSaturated), .arithTrap(arithTrap),
    .shiftResult(shiftResult), .shiftDone(shiftDone));
  x_write_sink XMEM (.clk_sys(clk_sys), .xWrEn(xWrEn), .xWrAddr(xWrAddr),
    .xWrData(xWrData), .peekAddr(peekAddr), .peekData(peekData),
    .wrCount(wrCount));
  ////////////////////////////////////////////////////////////////////////
  task automatic check(string n, logic [39:0] e, logic [39:0] s);
    checks++;
    if (s !== e)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic final_report();
    if (mismatches == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
    check("hresp", 1'b0, hresp);
  endtask
  task automatic loadAcc(logic b, logic [39:0] v);
    bus(1'b1, b ? `ADDR_ACCB_LO : `ADDR_ACCA_LO, v[31:0]);
    bus(1'b1, b ? `ADDR_ACCB_HI : `ADDR_ACCA_HI, {24'h0, v[39:32]});
  endtask
  task automatic op(op_code_e c, logic [15:0] d, logic w = 1'b1,
    logic a = 1'b0, mac_kind_e k = MK_MULT_ACC, wb_mode_e m = WB_NONE);
    @(posedge clk_sys);
    opValid <= 1'b1;
    opCode <= c;
    opAcc <= a;
    macKind <= k;
    wbMode <= m;
    @(posedge clk_sys);
    opValid <= 1'b0;
    #1;
    check("xWrEn", w, xWrEn);
    if (w)
    begin
      nWr++;
      check("xWrData", d, xWrData);
    end
    if (w && c != OP_MAC)
      check("xWrAddr", 16'hFFFE, xWrAddr);
  endtask
  task automatic add(logic b, logic [39:0] v);
    @(posedge clk_sys);
    addValid <= 1'b1;
    addAcc <= b;
    addOperand <= v;
    @(posedge clk_sys);
    addValid <= 1'b0;
    #1;
  endtask
  task automatic shf(shift_src_e s, int n, logic ar, logic mc,
    logic [39:0] e);
    @(posedge clk_sys);
    shiftValid <= 1'b1;
    shiftSrc <= s;
    shiftAmt <= 6'(n);
    shiftArith <= ar;
    shiftMcu <= mc;
    @(posedge clk_sys);
    shiftValid <= 1'b0;
    #1;
    check("shiftDone", 1'b1, shiftDone);
    check("shiftResult", e, shiftResult);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    #200000;
    mismatches++;
    final_report();
  end
  initial
  begin
    repeat (12) @(posedge clk_sys);
    arst_n <= 1'b1;
    bus(1'b0, `ADDR_WBPTR, 32'h0);
    check("wbptrReset", 32'h0, rd);
    // Truncate, conventional and convergent rounding
    loadAcc(1'b0, 40'h00_1234_8000);
    op(OP_STORE, 16'h1234);
    op(OP_STORE_ROUND, 16'h1235);
    loadAcc(1'b0, 40'h00_1234_7FFF);
    op(OP_STORE_ROUND, 16'h1234);
    bus(1'b1, `ADDR_CONFIG, 32'h1);
    op(OP_STORE_ROUND, 16'h1234);
    loadAcc(1'b0, 40'h00_1234_8000);
    op(OP_STORE_ROUND, 16'h1234);
    loadAcc(1'b0, 40'h00_1235_8000);
    op(OP_STORE_ROUND, 16'h1236);
    // Data write saturation
    loadAcc(1'b0, 40'h00_9000_0000);
    op(OP_STORE, 16'h9000);
    bus(1'b1, `ADDR_CONFIG, 32'h3);
    bus(1'b0, `ADDR_CONFIG, 32'h0);
    check("config", 32'h3, rd);
    op(OP_STORE, 16'h7FFF);
    op(OP_STORE_ROUND, 16'h7FFF);
    bus(1'b0, `ADDR_ACCA_LO, 32'h0);
    check("accALo", 32'h9000_0000, rd);
    loadAcc(1'b0, 40'hFF_7000_0000);
    op(OP_STORE, 16'h8000);
    loadAcc(1'b0, 40'hFF_FFFF_0000);
    op(OP_STORE, 16'hFFFF);
    // Write-back of the other accumulator
    bus(1'b1, `ADDR_CONFIG, 32'h0);
    loadAcc(1'b1, 40'h00_4321_8000);
    bus(1'b1, `ADDR_WBPTR, 32'h8000);
    op(OP_MAC, 16'h4322, 1'b1, 1'b0, MK_MULT_ACC, WB_INDIRECT);
    check("xWrAddr", 16'h8000, xWrAddr);
    check("wbPointer", 16'h8002, wbPointer);
    op(OP_MAC, 16'h0, 1'b0, 1'b0, MK_MULT_SUB, WB_DIRECT);
    check("wbPointer", 16'h4322, wbPointer);
    op(OP_MAC, 16'hFFFF, 1'b1, 1'b1, MK_CLEAR, WB_INDIRECT);
    op(OP_MAC, 16'hFFFF, 1'b1, 1'b1, MK_MOVE, WB_INDIRECT);
    check("wbPointer", 16'h4326, wbPointer);
    op(OP_MAC, 16'h0, 1'b0, 1'b0, MK_MULT_ACC, WB_NONE);
    for (int k = 4; k < 8; k++)
      op(OP_MAC, 16'h0, 1'b0, 1'b0, mac_kind_e'(k), WB_INDIRECT);
    check("wbPointer", 16'h4326, wbPointer);
    // Catastrophic overflow, flags and trap
    bus(1'b1, `ADDR_CONFIG, 32'h4);
    loadAcc(1'b0, 40'h7F_FFFF_FFFF);
    add(1'b0, 40'h1);
    check("flagA", 1'b1, accASaturated);
    check("trap", 1'b1, arithTrap);
    add(1'b0, 40'h1);
    check("flagA", 1'b1, accASaturated);
    check("trap", 1'b0, arithTrap);
    bus(1'b0, `ADDR_ACCA_HI, 32'h0);
    check("accAHi", 32'h80, rd);
    bus(1'b1, `ADDR_CONFIG, 32'h0);
    loadAcc(1'b1, 40'h80_0000_0000);
    add(1'b1, 40'hFF_FFFF_FFFF);
    check("flagB", 1'b1, accBSaturated);
    check("trap", 1'b0, arithTrap);
    bus(1'b1, `ADDR_STATUS, 32'h1);
    bus(1'b0, `ADDR_STATUS, 32'h0);
    check("status", 32'h2, rd);
    bus(1'b0, `ADDR_UNMAPPED, 32'h0);
    check("unmapped", 32'h0, rd);
    // Barrel shifter
    loadAcc(1'b0, 40'h80_0000_00F0);
    shf(SRC_ACC_A, 4, 1'b1, 1'b0, 40'hF8_0000_000F);
    shf(SRC_ACC_A, 4, 1'b0, 1'b0, 40'h08_0000_000F);
    shf(SRC_ACC_A, -4, 1'b0, 1'b0, 40'h00_0000_0F00);
    shf(SRC_ACC_A, 0, 1'b0, 1'b0, 40'h80_0000_00F0);
    shf(SRC_ACC_B, 16, 1'b0, 1'b0, 40'h00_007F_FFFF);
    shf(SRC_XBUS, 1, 1'b1, 1'b0, 40'hFF_C000_8000);
    shf(SRC_XBUS, -16, 1'b0, 1'b0, 40'h00_8001_0000);
    shf(SRC_XBUS, 1, 1'b0, 1'b1, 40'h00_0000_4000);
    shf(SRC_XBUS, -1, 1'b0, 1'b1, 40'h00_0000_0002);
    check("writes", nWr, wrCount);
    peekAddr <= 16'h8000;
    #1;
    check("xMem", 16'h4322, peekData);
    final_report();
  end
endmodule // accumulator_round_saturate_shift_tb_top
`default_nettype wire
